// ==== verilog/eip_defs.svh ====
// constants for the external interrupt pair and input select block
// assumes a 32-bit apb slave, byte address = register index * 4
`ifndef EIP_DEFS_SVH
`define EIP_DEFS_SVH

// register indices, byte address is four times these
`define EIP_IDX_PAIR_CTRL   16'hFE5E
`define EIP_IDX_INSEL       16'hFE5F
`define EIP_IDX_AUX_CTRL    16'hFE60
`define EIP_IDX_STATUS      16'hFE61
`define EIP_RESET_VAL       8'h00

// ext_irq_pair_control fields
`define EIP_CH3_RISE        7
`define EIP_CH3_FALL        6
`define EIP_CH3_FLAG        5
`define EIP_CH3_EN          4
`define EIP_CH2_RISE        3
`define EIP_CH2_FALL        2
`define EIP_CH2_FLAG        1
`define EIP_CH2_EN          0

// input_signal_select fields
`define EIP_HCAP_SEL        7
`define EIP_LCAP_SEL        6
`define EIP_BCLK_HI         5
`define EIP_BCLK_LO         4
`define EIP_BUZ_SEL         3
`define EIP_FILT_SEL        2
`define EIP_FILT_ON         1
`define EIP_CNT_SEL         0

// aux_control fields
`define EIP_CH0_LEVEL       0
`define EIP_CH0_POL         1
`define EIP_CH1_LEVEL       2
`define EIP_CH1_POL         3
`define EIP_PIN7_FUNC       4
`define EIP_PIN7_LATCH      5
`define EIP_CH4_LCAP        6
`define EIP_CH4_HCAP        7

// noise filter time constants in tcyc (1 tcyc = 1 clock)
`define EIP_FILT_SHORT      8'h01
`define EIP_FILT_MID        8'h20
`define EIP_FILT_LONG       8'h80

// buzzer divides the base timer clock by 16: toggle every 8 enables
`define EIP_BUZ_HALF_LAST   3'h7

`endif

// ==== verilog/eip_pkg.sv ====
// types shared by the external interrupt pair block
// assumes eip_defs.svh for numeric constants
package eip_pkg;

  typedef enum logic [1:0] {
    EIP_BCLK_SUB,
    EIP_BCLK_CYCLE,
    EIP_BCLK_PRESCALE
  } eip_bclk_t;

  typedef enum logic [1:0] {
    EIP_FILT_T1,
    EIP_FILT_T32,
    EIP_FILT_T128
  } eip_filt_t;

endpackage : eip_pkg

// ==== verilog/eip_filt_if.sv ====
// carrier between the top and the noise filter
// assumes one clock domain, raw input already synchronised
interface eip_filt_if;
  logic       raw;
  logic [7:0] len;
  logic       clean;

  modport user   (output raw, output len, input clean);
  modport filter (input raw, input len, output clean);
endinterface : eip_filt_if

// ==== verilog/eip_nfilt.sv ====
// noise filter: output follows input after len stable cycles
// assumes synchronised input on i_ref_clk
module eip_nfilt
  import eip_pkg::*;
(
  input  wire logic  i_ref_clk,
  input  wire logic  i_resetn,
  eip_filt_if.filter f
);
`include "eip_defs.svh"

  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       out_reg;
  logic       out_next;

  always_comb begin
    cnt_next = 8'h00;
    out_next = out_reg;
    if (f.raw != out_reg) begin
      if ((cnt_reg + 8'h01) >= f.len) begin
        out_next = f.raw;
      end else begin
        cnt_next = cnt_reg + 8'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt_reg <= 8'h00;
      out_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      out_reg <= out_next;
    end
  end

  assign f.clean = out_reg;

endmodule : eip_nfilt

// ==== verilog/eip_top.sv ====
// external interrupt pair, input select routing and apb register file
// assumes apb master on i_ref_clk; pins are asynchronous to it
//
// What this block does
// RQ1: channel three on port1_pin5 detects none, falling, rising or both edges.
// RQ2: channel two on port1_pin6 uses the same two-bit edge choice.
// RQ3: channel three sets its flag; flag and enable request vector 001BH.
// RQ4: channel two flag and enable give hold release and vector 0013H request.
// RQ5: flags never clear by themselves; software clears them by writing.
// RQ6: in hold, edges toward the entry level of port1_pin6 set no flag.
// RQ7: software should pick both edges when port1_pin6 wakes from hold.
// RQ8: high capture select one: channel one detections capture, every cycle in level.
// RQ9: high capture select zero: channel three detections give high capture.
// RQ10: low capture select one: channel zero detections capture, every cycle in level.
// RQ11: low capture select zero: channel two detections give low capture.
// RQ12: base clock select: 00/10 subclock, 01 cycle clock, 11 prescaler.
// RQ13: buzzer select one: pwm forced high, base clock over 16 drives pin7.
// RQ14: buzzer select zero: buzzer held high, pwm routed toward pin7.
// RQ15: filter constant: 00/10 one cycle, 01 128 cycles, 11 32 cycles.
// RQ16: count source one takes channel three, zero takes channel two.
// RQ17: channel four chosen as capture source masks the pin capture paths.
// RQ18: channels zero and one: falling, low level, rising, high level.
// RQ19: pin7 output uses selection only with function bit, xored with latch.
// RQ20: pins synchronised, detections are one-cycle pulses, registers reset zero (the buzzer output register buz_out_reg resets high).
module eip_top
  import eip_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_port1_pin5,
  input  wire logic        i_port1_pin6,
  input  wire logic        i_port1_pin7,
  input  wire logic        i_port7_pin0,
  input  wire logic        i_hold_mode,
  input  wire logic        i_subclk_en,
  input  wire logic        i_prescale_en,
  input  wire logic        i_pwm_high_output,
  output logic             o_irq_req_001b,
  output logic             o_irq_req_0013,
  output logic             o_hold_release,
  output logic             o_t0_high_capture,
  output logic             o_t0_low_capture,
  output logic             o_t0_count,
  output logic             o_base_clk_en,
  output logic             o_buzzer,
  output logic             o_pwm_high_gated,
  output logic             o_port1_pin7
);
`include "eip_defs.svh"

  // --------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------
  function automatic logic addr_hit(input logic [31:0] a, input logic [15:0] idx);
    addr_hit = (a == {14'h0000, idx, 2'b00});
  endfunction : addr_hit

  function automatic logic edge_hit(input logic rise, input logic fall,
                                    input logic rise_en, input logic fall_en);
    edge_hit = (rise & rise_en) | (fall & fall_en);
  endfunction : edge_hit

  function automatic logic lvl_hit(input logic lvl, input logic rise, input logic fall,
                                   input logic pol, input logic level_mode);
    if (level_mode) begin
      lvl_hit = (lvl == pol);
    end else begin
      lvl_hit = pol ? rise : fall;
    end
  endfunction : lvl_hit

  // --------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------
  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [3:0] prev_reg;
  logic [3:0] pins_now;
  logic [3:0] sync1_next;
  logic [3:0] sync2_next;
  logic [3:0] prev_next;
  logic       p70_clean;

  always_comb begin
    sync1_next = {i_port7_pin0, i_port1_pin7, i_port1_pin6, i_port1_pin5};
    sync2_next = sync1_reg;
    prev_next  = pins_now;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
      prev_reg  <= 4'h0;
    end else begin
      sync1_reg <= sync1_next;  // [RQ20]
      sync2_reg <= sync2_next;
      prev_reg  <= prev_next;
    end
  end

  // bit3 is the filtered port7_pin0
  assign pins_now = {p70_clean, sync2_reg[2:0]};

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  logic [7:0] pair_ctrl_reg;
  logic [7:0] pair_ctrl_next;
  logic [7:0] insel_reg;
  logic [7:0] insel_next;
  logic [7:0] aux_reg;
  logic [7:0] aux_next;
  logic       hold_lvl_reg;
  logic       hold_lvl_next;
  logic       hold_prev_reg;
  logic       hold_prev_next;
  logic       wr_en;
  logic       rd_en;
  logic       mapped;
  logic       ch3_set;
  logic       ch2_set;

  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign mapped = addr_hit(paddr, `EIP_IDX_PAIR_CTRL) | addr_hit(paddr, `EIP_IDX_INSEL)
                | addr_hit(paddr, `EIP_IDX_AUX_CTRL) | addr_hit(paddr, `EIP_IDX_STATUS);

  always_comb begin
    pair_ctrl_next = pair_ctrl_reg;
    insel_next     = insel_reg;
    aux_next       = aux_reg;
    if (wr_en && addr_hit(paddr, `EIP_IDX_PAIR_CTRL)) begin
      pair_ctrl_next = pwdata[7:0];  // [RQ5]
    end
    if (wr_en && addr_hit(paddr, `EIP_IDX_INSEL)) begin
      insel_next = pwdata[7:0];
    end
    if (wr_en && addr_hit(paddr, `EIP_IDX_AUX_CTRL)) begin
      aux_next = pwdata[7:0];
    end
    // hardware set wins over a clearing write
    if (ch3_set) begin
      pair_ctrl_next[`EIP_CH3_FLAG] = 1'b1;  // [RQ3]
    end
    if (ch2_set) begin
      pair_ctrl_next[`EIP_CH2_FLAG] = 1'b1;  // [RQ4]
    end
    // snapshot port1_pin6 on hold entry
    hold_prev_next = i_hold_mode;
    hold_lvl_next  = hold_lvl_reg;
    if (i_hold_mode && !hold_prev_reg) begin
      hold_lvl_next = pins_now[1];  // [RQ6]
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pair_ctrl_reg <= `EIP_RESET_VAL;  // [RQ20]
      insel_reg     <= `EIP_RESET_VAL;
      aux_reg       <= `EIP_RESET_VAL;
      hold_lvl_reg  <= 1'b0;
      hold_prev_reg <= 1'b0;
    end else begin
      pair_ctrl_reg <= pair_ctrl_next;
      insel_reg     <= insel_next;
      aux_reg       <= aux_next;
      hold_lvl_reg  <= hold_lvl_next;
      hold_prev_reg <= hold_prev_next;
    end
  end

  // --------------------------------------------------------------------
  // apb read side
  // --------------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_en) begin
      if (addr_hit(paddr, `EIP_IDX_PAIR_CTRL)) begin
        prdata = {24'h00_0000, pair_ctrl_reg};
      end else if (addr_hit(paddr, `EIP_IDX_INSEL)) begin
        prdata = {24'h00_0000, insel_reg};
      end else if (addr_hit(paddr, `EIP_IDX_AUX_CTRL)) begin
        prdata = {24'h00_0000, aux_reg};
      end else if (addr_hit(paddr, `EIP_IDX_STATUS)) begin
        prdata = {26'h000_0000, hold_prev_reg, hold_lvl_reg, pins_now};
      end
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // --------------------------------------------------------------------
  // noise filter on port7_pin0
  // --------------------------------------------------------------------
  eip_filt_t  filt_mode;
  logic [7:0] filt_len;
  eip_filt_if filt_bus ();

  always_comb begin
    case ({insel_reg[`EIP_FILT_SEL], insel_reg[`EIP_FILT_ON]})
      2'b01:   filt_mode = EIP_FILT_T128;  // [RQ15]
      2'b11:   filt_mode = EIP_FILT_T32;
      default: filt_mode = EIP_FILT_T1;
    endcase
    case (filt_mode)
      EIP_FILT_T128: filt_len = `EIP_FILT_LONG;
      EIP_FILT_T32:  filt_len = `EIP_FILT_MID;
      default:       filt_len = `EIP_FILT_SHORT;
    endcase
  end

  assign filt_bus.raw = sync2_reg[3];
  assign filt_bus.len = filt_len;
  assign p70_clean    = filt_bus.clean;

  eip_nfilt u_nfilt (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .f         (filt_bus)
  );

  // --------------------------------------------------------------------
  // detectors
  // --------------------------------------------------------------------
  logic [3:0] rise;
  logic [3:0] fall;
  logic       ch3_hit;
  logic       ch2_hit;
  logic       ch1_hit;
  logic       ch0_hit;
  logic       ch2_block;

  assign rise = pins_now & ~prev_reg;  // [RQ20]
  assign fall = ~pins_now & prev_reg;

  assign ch3_hit = edge_hit(rise[0], fall[0], pair_ctrl_reg[`EIP_CH3_RISE],
                            pair_ctrl_reg[`EIP_CH3_FALL]);  // [RQ1]
  assign ch2_hit = edge_hit(rise[1], fall[1], pair_ctrl_reg[`EIP_CH2_RISE],
                            pair_ctrl_reg[`EIP_CH2_FALL]);  // [RQ2]
  assign ch1_hit = lvl_hit(pins_now[2], rise[2], fall[2], aux_reg[`EIP_CH1_POL],
                           aux_reg[`EIP_CH1_LEVEL]);  // [RQ18]
  assign ch0_hit = lvl_hit(pins_now[3], rise[3], fall[3], aux_reg[`EIP_CH0_POL],
                           aux_reg[`EIP_CH0_LEVEL]);  // [RQ18]

  // in hold an edge back toward the entry level is not a wake event
  assign ch2_block = hold_prev_reg & ((rise[1] & hold_lvl_reg) | (fall[1] & ~hold_lvl_reg));
  assign ch3_set   = ch3_hit;
  assign ch2_set   = ch2_hit & ~ch2_block;  // [RQ6]

  assign o_irq_req_001b = pair_ctrl_reg[`EIP_CH3_FLAG] & pair_ctrl_reg[`EIP_CH3_EN];  // [RQ3]
  assign o_irq_req_0013 = pair_ctrl_reg[`EIP_CH2_FLAG] & pair_ctrl_reg[`EIP_CH2_EN];  // [RQ4]
  assign o_hold_release = o_irq_req_0013;  // [RQ4] [RQ7]

  // --------------------------------------------------------------------
  // timer 0 capture and count routing, base clock
  // --------------------------------------------------------------------
  eip_bclk_t bclk_mode;
  logic      hcap_next;
  logic      lcap_next;
  logic      cnt_next;
  logic      bclk_next;
  logic      hcap_reg;
  logic      lcap_reg;
  logic      cnt_reg;
  logic      bclk_reg;

  always_comb begin
    case ({insel_reg[`EIP_BCLK_HI], insel_reg[`EIP_BCLK_LO]})
      2'b01:   bclk_mode = EIP_BCLK_CYCLE;  // [RQ12]
      2'b11:   bclk_mode = EIP_BCLK_PRESCALE;
      default: bclk_mode = EIP_BCLK_SUB;
    endcase
    case (bclk_mode)
      EIP_BCLK_CYCLE:    bclk_next = 1'b1;
      EIP_BCLK_PRESCALE: bclk_next = i_prescale_en;
      default:           bclk_next = i_subclk_en;
    endcase
    hcap_next = (insel_reg[`EIP_HCAP_SEL] ? ch1_hit : ch3_hit)  // [RQ8] [RQ9]
              & ~aux_reg[`EIP_CH4_HCAP];  // [RQ17]
    lcap_next = (insel_reg[`EIP_LCAP_SEL] ? ch0_hit : ch2_hit)  // [RQ10] [RQ11]
              & ~aux_reg[`EIP_CH4_LCAP];  // [RQ17]
    cnt_next  = insel_reg[`EIP_CNT_SEL] ? ch3_hit : ch2_hit;  // [RQ16]
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hcap_reg <= 1'b0;
      lcap_reg <= 1'b0;
      cnt_reg  <= 1'b0;
      bclk_reg <= 1'b0;
    end else begin
      hcap_reg <= hcap_next;
      lcap_reg <= lcap_next;
      cnt_reg  <= cnt_next;
      bclk_reg <= bclk_next;
    end
  end

  assign o_t0_high_capture = hcap_reg;
  assign o_t0_low_capture  = lcap_reg;
  assign o_t0_count        = cnt_reg;
  assign o_base_clk_en     = bclk_reg;

  // --------------------------------------------------------------------
  // buzzer and pin7 output
  // --------------------------------------------------------------------
  logic [2:0] buz_div_reg;
  logic [2:0] buz_div_next;
  logic       buz_sq_reg;
  logic       buz_sq_next;
  logic       buz_out_reg;
  logic       buz_out_next;
  logic       pwm_out_reg;
  logic       pwm_out_next;
  logic       pin7_reg;
  logic       pin7_next;
  logic       pin7_sel;

  always_comb begin
    buz_div_next = buz_div_reg;
    buz_sq_next  = buz_sq_reg;
    if (bclk_reg) begin
      buz_div_next = buz_div_reg + 3'h1;
      if (buz_div_reg == `EIP_BUZ_HALF_LAST) begin
        buz_sq_next = ~buz_sq_reg;  // [RQ13]
      end
    end
    buz_out_next = insel_reg[`EIP_BUZ_SEL] ? buz_sq_reg : 1'b1;  // [RQ13] [RQ14]
    pwm_out_next = insel_reg[`EIP_BUZ_SEL] ? 1'b1 : i_pwm_high_output;  // [RQ13] [RQ14]
    pin7_sel     = insel_reg[`EIP_BUZ_SEL] ? buz_sq_reg : i_pwm_high_output;
    pin7_next    = aux_reg[`EIP_PIN7_FUNC] ? (pin7_sel ^ aux_reg[`EIP_PIN7_LATCH])  // [RQ19]
                                           : aux_reg[`EIP_PIN7_LATCH];
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      buz_div_reg <= 3'h0;
      buz_sq_reg  <= 1'b0;
      buz_out_reg <= 1'b1;
      pwm_out_reg <= 1'b0;
      pin7_reg    <= 1'b0;
    end else begin
      buz_div_reg <= buz_div_next;
      buz_sq_reg  <= buz_sq_next;
      buz_out_reg <= buz_out_next;
      pwm_out_reg <= pwm_out_next;
      pin7_reg    <= pin7_next;
    end
  end

  assign o_buzzer         = buz_out_reg;
  assign o_pwm_high_gated = pwm_out_reg;
  assign o_port1_pin7     = pin7_reg;

endmodule : eip_top

// ==== verif/eip_top_monitor.sv ====
// assertions on the top ports of the interrupt pair block
// assumes one clock, async active-low reset, apb byte addresses
module eip_top_monitor (
  input wire logic        i_ref_clk,
  input wire logic        i_resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        o_irq_req_001b,
  input wire logic        o_irq_req_0013,
  input wire logic        o_hold_release,
  input wire logic        o_base_clk_en,
  input wire logic        o_buzzer,
  input wire logic        o_pwm_high_gated,
  input wire logic        o_port1_pin7
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_PAIR = 32'h0003F978;
  localparam logic [31:0] A_INS  = 32'h0003F97C;
  localparam logic [31:0] A_AUX  = 32'h0003F980;
  logic       wr;
  logic [7:0] ctl_reg, ctl_next, ins_reg, ins_next, aux_reg, aux_next;
  assign wr = psel & penable & pwrite;
  // shadow copies of the written control bits
  always_comb begin
    ctl_next = ctl_reg;
    ins_next = ins_reg;
    aux_next = aux_reg;
    if (wr && paddr == A_PAIR) ctl_next = pwdata[7:0];
    if (wr && paddr == A_INS) ins_next = pwdata[7:0];
    if (wr && paddr == A_AUX) aux_next = pwdata[7:0];
  end
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctl_reg <= 8'h00;
      ins_reg <= 8'h00;
      aux_reg <= 8'h00;
    end else begin
      ctl_reg <= ctl_next;
      ins_reg <= ins_next;
      aux_reg <= aux_next;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  sequence s_buz_on;
    ins_reg[3] [*2];
  endsequence
  sequence s_buz_off;
    !ins_reg[3] [*2];
  endsequence
  sequence s_bclk_cyc;
    (ins_reg[5:4] == 2'h1) [*2];
  endsequence
  sequence s_pin7_plain;
    !aux_reg[4] [*2];
  endsequence
  property p_hold;
    (o_hold_release == o_irq_req_0013) && (!o_hold_release || ctl_reg[0]);
  endproperty
  property p_irq3_en;
    o_irq_req_001b |-> ctl_reg[4];
  endproperty
  property p_keep3;
    $fell(o_irq_req_001b) |-> $past(wr && paddr == A_PAIR);
  endproperty
  property p_set3;
    $rose(o_irq_req_001b) && !$past(wr) |-> $past(ctl_reg[7:6]) != 2'h0;
  endproperty
  property p_buz_off;
    s_buz_off |-> o_buzzer;
  endproperty
  property p_pwm_forced;
    s_buz_on |-> o_pwm_high_gated;
  endproperty
  property p_bclk;
    s_bclk_cyc |-> o_base_clk_en;
  endproperty
  property p_pin7;
    s_pin7_plain |-> o_port1_pin7 == $past(aux_reg[5]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold release differs from request");
  a_irq3_en: assert property (p_irq3_en)
    else $error("request without enable");
  a_keep3: assert property (p_keep3)
    else $error("flag dropped without write");
  a_set3: assert property (p_set3)
    else $error("flag set with detection off");
  a_buz_off: assert property (p_buz_off)
    else $error("buzzer not high");
  a_pwm_forced: assert property (p_pwm_forced)
    else $error("pwm not forced high");
  a_bclk: assert property (p_bclk)
    else $error("base enable missing");
  a_pin7: assert property (p_pin7)
    else $error("pin7 not latch");
endmodule : eip_top_monitor

bind eip_top eip_top_monitor u_mon (
  .i_ref_clk, .i_resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .o_irq_req_001b, .o_irq_req_0013, .o_hold_release, .o_base_clk_en,
  .o_buzzer, .o_pwm_high_gated, .o_port1_pin7
);

// ==== verif/eip_pins.sv ====
// far-side model: pin levels and timer enable pulses
// assumes the bench changes i_lvl just after rising edges
module eip_pins (
  input  wire logic       i_ref_clk,
  input  wire logic       i_resetn,
  input  wire logic [3:0] i_lvl,
  output logic      [3:0] o_pins,
  output logic            o_subclk_en,
  output logic            o_prescale_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_reg;
  // subclock every 4 cycles, prescaler every 2
  always_ff @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      div_reg       <= 2'h0;
      o_pins        <= 4'h0;
      o_subclk_en   <= 1'h0;
      o_prescale_en <= 1'h0;
    end else begin
      div_reg       <= div_reg + 2'h1;
      o_pins        <= i_lvl;
      o_subclk_en   <= (div_reg == 2'h3);
      o_prescale_en <= div_reg[0];
    end
  end
endmodule : eip_pins

// ==== verif/eip_top_tb.sv ====
// bench for the interrupt pair block: apb master, pin model, scenarios
// assumes eip_top, eip_pins and the bound monitor are compiled
module eip_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_PAIR = 32'h0003F978;
  localparam logic [31:0] A_INS  = 32'h0003F97C;
  localparam logic [31:0] A_AUX  = 32'h0003F980;
  localparam logic [31:0] A_STAT = 32'h0003F984;
  localparam logic [31:0] A_BAD  = 32'h0003F990;
  logic        clk, resetn, psel, penable, pwrite, hold, pwm, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0]  lvl, pin;
  logic        sub_en, pre_en, irq3, irq2, hrel, hcap, lcap, cnt, bclk, buz, pwmg, p17;
  logic        bz_q;
  int          n_mismatch, comparisons, n_hc, n_lc, n_ct, n_bc, n_bz;

  eip_pins u_pins (.i_ref_clk(clk), .i_resetn(resetn), .i_lvl(lvl), .o_pins(pin),
    .o_subclk_en(sub_en), .o_prescale_en(pre_en));
  eip_top u_dut (.i_ref_clk(clk), .i_resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .i_port1_pin5(pin[0]), .i_port1_pin6(pin[1]),
    .i_port1_pin7(pin[2]), .i_port7_pin0(pin[3]), .i_hold_mode(hold),
    .i_subclk_en(sub_en), .i_prescale_en(pre_en), .i_pwm_high_output(pwm),
    .o_irq_req_001b(irq3), .o_irq_req_0013(irq2), .o_hold_release(hrel),
    .o_t0_high_capture(hcap), .o_t0_low_capture(lcap), .o_t0_count(cnt),
    .o_base_clk_en(bclk), .o_buzzer(buz), .o_pwm_high_gated(pwmg), .o_port1_pin7(p17));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // pulse counters, sampled away from the launching edge
  always @(negedge clk) begin
    if (hcap === 1'h1) n_hc++;
    if (lcap === 1'h1) n_lc++;
    if (cnt === 1'h1) n_ct++;
    if (bclk === 1'h1) n_bc++;
    if (buz !== bz_q) n_bz++;
    bz_q = buz;
  end

  task automatic finish_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel   <= 1'h1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) begin
      chk("pready_timeout", pready, 1'h1);
      finish_test;
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask : apb

  task automatic pins(input logic [3:0] v, input int n);
    lvl <= v;
    repeat (n) @(posedge clk);
  endtask : pins

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [31:0] q;
    logic        e;
    apb(1'h0, A_PAIR, 32'h0, q, e);
    chk("pair_reset", q, 32'h0);
    apb(1'h0, A_INS, 32'h0, q, e);
    chk("insel_reset", q, 32'h0);
    apb(1'h1, A_INS, 32'hFFFFFF5A, q, e);
    apb(1'h0, A_INS, 32'h0, q, e);
    chk("insel_rw", q, 32'h5A);
    apb(1'h1, A_BAD, 32'hFF, q, e);
    chk("bad_wr_err", e, 1'h1);
    apb(1'h0, A_BAD, 32'h0, q, e);
    chk("bad_rd", {e, q[30:0]}, 32'h80000000);
    apb(1'h1, A_INS, 32'h0, q, e);
  endtask : t_regs

  task automatic t_edges;
    logic [31:0] q;
    logic        e;
    logic [1:0]  m, m2;
    int          h, l, c;
    for (int i = 0; i < 4; i++) begin
      m  = 2'(i);
      m2 = {m[0], m[1]};
      apb(1'h1, A_INS, {31'h0, m[0]}, q, e);
      apb(1'h1, A_PAIR, {24'h0, m, 2'h1, m2, 2'h1}, q, e);
      h = n_hc;
      l = n_lc;
      c = n_ct;
      pins(4'h3, 8);
      chk("hcap_ch3", n_hc - h, m[1]);
      chk("lcap_ch2", n_lc - l, m2[1]);
      chk("count_src", n_ct - c, m[0] ? m[1] : m2[1]);
      chk("irq_001b", irq3, m[1]);
      chk("irq_0013", irq2, m2[1]);
      apb(1'h0, A_PAIR, 32'h0, q, e);
      chk("flags_rise", q, {24'h0, m, m[1], 1'h1, m2, m2[1], 1'h1});
      pins(4'h0, 8);
      apb(1'h0, A_PAIR, 32'h0, q, e);
      chk("flags_kept", q, {24'h0, m, |m, 1'h1, m2, |m2, 1'h1});
      apb(1'h1, A_PAIR, 32'h0, q, e);
    end
  endtask : t_edges

  task automatic t_hold;
    logic [31:0] q;
    logic        e;
    pins(4'h2, 8);
    apb(1'h1, A_PAIR, 32'h9, q, e);
    hold <= 1'h1;
    repeat (4) @(posedge clk);
    apb(1'h0, A_STAT, 32'h0, q, e);
    chk("hold_snap", q, 32'h32);
    pins(4'h0, 8);
    pins(4'h2, 8);
    chk("hold_rise", hrel, 1'h0);
    apb(1'h1, A_PAIR, 32'hD, q, e);
    pins(4'h0, 8);
    chk("hold_fall", hrel, 1'h1);
    hold <= 1'h0;
    apb(1'h1, A_PAIR, 32'h0, q, e);
  endtask : t_hold

  task automatic t_route;
    logic [31:0] q;
    logic        e;
    int          b;
    pwm <= 1'h1;
    apb(1'h1, A_AUX, 32'h30, q, e);
    repeat (3) @(posedge clk);
    chk("pin7_xor", p17, 1'h0);
    chk("pwm_pass", pwmg, 1'h1);
    chk("buz_high", buz, 1'h1);
    pwm <= 1'h0;
    apb(1'h1, A_INS, 32'h18, q, e);
    repeat (4) @(posedge clk);
    chk("pwm_forced", pwmg, 1'h1);
    b = n_bz;
    repeat (64) @(posedge clk);
    chk("buz_toggles", n_bz - b, 8);
    for (int i = 0; i < 4; i++) begin
      apb(1'h1, A_INS, {26'h0, 2'(i), 4'h0}, q, e);
      repeat (4) @(posedge clk);
      b = n_bc;
      repeat (40) @(posedge clk);
      chk("base_clk", n_bc - b, i == 1 ? 40 : (i == 3 ? 20 : 10));
    end
    apb(1'h1, A_AUX, 32'h20, q, e);
    repeat (3) @(posedge clk);
    chk("pin7_latch", p17, 1'h1);
  endtask : t_route

  task automatic t_level;
    logic [31:0] q;
    logic        e;
    int          h, l, n;
    apb(1'h1, A_AUX, 32'hD, q, e);
    apb(1'h1, A_INS, 32'hC0, q, e);
    pins(4'h4, 8);
    h = n_hc;
    l = n_lc;
    repeat (20) @(posedge clk);
    chk("hcap_level", n_hc - h, 20);
    chk("lcap_level", n_lc - l, 20);
    apb(1'h1, A_AUX, 32'hCD, q, e);
    repeat (4) @(posedge clk);
    h = n_hc;
    l = n_lc;
    repeat (20) @(posedge clk);
    chk("hcap_masked", n_hc - h, 0);
    chk("lcap_masked", n_lc - l, 0);
    apb(1'h1, A_AUX, 32'h2, q, e);
    for (int i = 0; i < 2; i++) begin
      n = i ? 32 : 128;
      apb(1'h1, A_INS, i ? 32'h46 : 32'h42, q, e);
      l = n_lc;
      pins(4'h8, n - 4);
      chk("filt_early", n_lc - l, 0);
      pins(4'h8, 16);
      chk("filt_late", n_lc - l, 1);
      pins(4'h0, n + 16);
    end
  endtask : t_level

  initial begin
    resetn  = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    lvl     = 4'h0;
    hold    = 1'h0;
    pwm     = 1'h0;
    repeat (8) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    t_regs;
    t_edges;
    t_hold;
    t_route;
    t_level;
    finish_test;
  end
endmodule : eip_top_tb
